// >>> dv/vcw_top_checker.sv
`timescale 1ns/100ps

// ----------------------------------------------------------------------
// Port watcher for the vertical crop window
// ----------------------------------------------------------------------
module vcw_top_checker #(
   parameter int DATA_W = 24
) (
   // Clock and reset
   input wire logic              clk,
   input wire logic              rst,
   // Register port
   input wire logic [7:0]        reg_addr,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [7:0]        reg_rdata,
   // Crop enables
   input wire logic              crop_enable_p0,
   input wire logic              crop_enable_p1,
   // Video in
   input wire logic              vid_frame_start,
   input wire logic              vid_pixel_valid_flag,
   input wire logic [DATA_W-1:0] vid_data,
   // Video out
   input wire logic              tx0_pixel_valid_flag,
   input wire logic [DATA_W-1:0] tx0_data,
   input wire logic              tx1_pixel_valid_flag,
   input wire logic [DATA_W-1:0] tx1_data
);
   // One clock domain, so clocking and reset are given once
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // Read data only stands in the cycle after a read strobe
   chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not idle");
   chk_first_reserved: assert property (reg_rd && reg_addr == 8'h3B |=>
      reg_rdata[7:5] == 3'h0)
      else $error("first line high byte shows upper bits");
   chk_last_reserved: assert property (reg_rd && reg_addr == 8'h3D |=>
      reg_rdata[7:5] == 3'h0)
      else $error("last line high byte shows upper bits");
   // Blanked pixels carry no data
   chk_blank_data0: assert property (!tx0_pixel_valid_flag |-> tx0_data == '0)
      else $error("port 0 blank pixel carries data");
   chk_blank_data1: assert property (!tx1_pixel_valid_flag |-> tx1_data == '0)
      else $error("port 1 blank pixel carries data");
   // A kept pixel is the input pixel one cycle late
   chk_valid_cause0: assert property (tx0_pixel_valid_flag |->
      $past(vid_pixel_valid_flag) && tx0_data == $past(vid_data))
      else $error("port 0 pixel without matching input");
   // With cropping off the flag follows the input
   chk_pass_uncropped1: assert property (!$past(rst) && !$past(crop_enable_p1) |->
      tx1_pixel_valid_flag == $past(vid_pixel_valid_flag))
      else $error("port 1 cropped while disabled");
   // The keep decision holds for a whole line, never split mid-run
   chk_line_steady: assert property (tx0_pixel_valid_flag && vid_pixel_valid_flag &&
      $past(vid_pixel_valid_flag) && !vid_frame_start && !reg_wr && !$past(reg_wr) &&
      crop_enable_p0 && $past(crop_enable_p0) |=> tx0_pixel_valid_flag)
      else $error("port 0 line split by crop");
endmodule

bind vcw_top vcw_top_checker #(.DATA_W(DATA_W)) chk_u (
   .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .crop_enable_p0(crop_enable_p0), .crop_enable_p1(crop_enable_p1),
   .vid_frame_start(vid_frame_start), .vid_pixel_valid_flag(vid_pixel_valid_flag),
   .vid_data(vid_data), .tx0_pixel_valid_flag(tx0_pixel_valid_flag), .tx0_data(tx0_data),
   .tx1_pixel_valid_flag(tx1_pixel_valid_flag), .tx1_data(tx1_data));

// >>> dv/vcw_video_sink.sv
`timescale 1ns/100ps

// ----------------------------------------------------------------------
// Transmit path model: summarises one port's frame
// ----------------------------------------------------------------------
module vcw_video_sink #(
   parameter int DATA_W = 24
) (
   // Clock and reset
   input wire logic              clk,
   input wire logic              rst,
   // One port of the transmit path
   input wire logic              pixel_valid_flag,
   input wire logic [DATA_W-1:0] data,
   input wire logic              hsync,
   input wire logic              vsync,
   // Frame summary
   output logic      [15:0]      first_kept,
   output logic      [15:0]      last_kept,
   output logic      [15:0]      kept_count,
   output logic      [15:0]      data_errs
);
   logic [15:0] line_q;

   // Lines are told apart by hsync, since blanked lines carry no flag
   always_ff @(posedge clk) begin
      if (rst || vsync) begin
         line_q     <= 16'hFFFF;
         first_kept <= 16'hFFFF;
         last_kept  <= 16'hFFFF;
         kept_count <= 16'h0000;
         data_errs  <= 16'h0000;
      end else begin
         if (hsync) begin
            line_q <= line_q + 16'h0001;
         end
         if (pixel_valid_flag) begin
            kept_count <= kept_count + 16'h0001;
            last_kept  <= line_q;
            if (first_kept == 16'hFFFF) begin
               first_kept <= line_q;
            end
            if (data[15:0] !== line_q) begin
               data_errs <= data_errs + 16'h0001; // Pixel from the wrong line
            end
         end
      end
   end
endmodule

// >>> dv/video_vertical_crop_window_tb.sv
`timescale 1ns/100ps

// ----------------------------------------------------------------------
// Bench for the vertical crop window
// ----------------------------------------------------------------------
module video_vertical_crop_window_tb;
   localparam int DW = 24;
   logic          clk = 1'b0;
   logic          rst = 1'b1;
   logic [7:0]    reg_addr = 8'h00;
   logic [7:0]    reg_wdata = 8'h00;
   logic          reg_wr = 1'b0;
   logic          reg_rd = 1'b0;
   logic [7:0]    reg_rdata;
   logic          multi = 1'b0;
   logic          psel = 1'b0;
   logic          en0 = 1'b0;
   logic          en1 = 1'b0;
   logic          fs = 1'b0;
   logic          pv = 1'b0;
   logic [DW-1:0] vdata = '0;
   logic          hs = 1'b0;
   logic          vs = 1'b0;
   logic          tv[2];
   logic [DW-1:0] td[2];
   logic          th[2];
   logic          tvs[2];
   logic [15:0]   fk[2];
   logic [15:0]   lk[2];
   logic [15:0]   kc[2];
   logic [15:0]   de[2];
   int            errors = 0;
   int            checks = 0;

   // 25 MHz clock
   always #20 clk = ~clk;

   vcw_top #(.DATA_W(DW)) dut_u (
      .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .multi_port_mode(multi), .port_select(psel),
      .crop_enable_p0(en0), .crop_enable_p1(en1), .vid_frame_start(fs),
      .vid_pixel_valid_flag(pv), .vid_data(vdata), .vid_hsync(hs), .vid_vsync(vs),
      .tx0_pixel_valid_flag(tv[0]), .tx0_data(td[0]), .tx0_hsync(th[0]), .tx0_vsync(tvs[0]),
      .tx1_pixel_valid_flag(tv[1]), .tx1_data(td[1]), .tx1_hsync(th[1]), .tx1_vsync(tvs[1]));

   // One transmit path model per port
   for (genvar g = 0; g < 2; g++) begin : g_sink
      vcw_video_sink #(.DATA_W(DW)) sink_u (
         .clk(clk), .rst(rst), .pixel_valid_flag(tv[g]), .data(td[g]), .hsync(th[g]),
         .vsync(tvs[g]), .first_kept(fk[g]), .last_kept(lk[g]), .kept_count(kc[g]),
         .data_errs(de[g]));
   end

   task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic chk_num(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Register port: one-cycle strobes, read data one cycle later
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      // Data stands for this one cycle: look mid-cycle, hand back on the edge
      @(negedge clk);
      chk_byte("register read", exp, reg_rdata);
      @(posedge clk);
   endtask

   task automatic set_win(input logic [12:0] f, input logic [12:0] l);
      wr(8'h3A, f[7:0]);
      wr(8'h3B, {3'h0, f[12:8]});
      wr(8'h3C, l[7:0]);
      wr(8'h3D, {3'h0, l[12:8]});
   endtask

   // Frame: start pulse, then per line an hsync, np pixels and a gap
   task automatic send_frame(input int nl, input int np);
      @(posedge clk);
      fs <= 1'b1;
      vs <= 1'b1;
      @(posedge clk);
      fs <= 1'b0;
      vs <= 1'b0;
      for (int l = 0; l < nl; l++) begin
         hs <= 1'b1;
         @(posedge clk);
         hs <= 1'b0;
         for (int p = 0; p < np; p++) begin
            pv <= 1'b1;
            vdata <= {8'hA5, l[15:0]};
            @(posedge clk);
         end
         pv <= 1'b0;
         vdata <= '0;
         @(posedge clk);
      end
      repeat (3) @(posedge clk);
   endtask

   task automatic check_port(input int p, input logic [15:0] f, input logic [15:0] l,
                             input logic [15:0] k);
      chk_num("first kept line", f, fk[p]);
      chk_num("last kept line", l, lk[p]);
      chk_num("kept pixels", k, kc[p]);
      chk_num("pixel data faults", 16'h0000, de[p]);
   endtask

   task automatic t_reg_access();
      for (int i = 0; i < 4; i++) rd(8'h3A + i[7:0], 8'h00);
      wr(8'h3B, 8'hFF);
      wr(8'h3D, 8'hFF);
      rd(8'h3B, 8'h1F);
      rd(8'h3D, 8'h1F);
      wr(8'h3A, 8'h5A);
      wr(8'h3C, 8'hC3);
      rd(8'h3A, 8'h5A);
      rd(8'h3C, 8'hC3);
      rd(8'h00, 8'h00);
   endtask

   // Windows inside, at zero, inverted and above 255; port 1 left uncropped
   task automatic t_windows();
      logic [12:0] wf[4] = '{13'h0002, 13'h0000, 13'h0005, 13'h0101};
      logic [12:0] wl[4] = '{13'h0004, 13'h0000, 13'h0003, 13'h0102};
      int          nl[4] = '{7, 4, 7, 260};
      int          np[4] = '{3, 3, 2, 1};
      logic [15:0] ef;
      logic [15:0] el;
      logic [15:0] ek;
      en0 <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         set_win(wf[i], wl[i]);
         send_frame(nl[i], np[i]);
         ef = (wf[i] <= wl[i]) ? {3'h0, wf[i]} : 16'hFFFF;
         el = (wf[i] <= wl[i]) ? {3'h0, wl[i]} : 16'hFFFF;
         ek = (wf[i] <= wl[i]) ? (el - ef + 16'h0001) * np[i][15:0] : 16'h0000;
         check_port(0, ef, el, ek);
         check_port(1, 16'h0000, nl[i][15:0] - 16'h0001, (nl[i] * np[i]) & 16'hFFFF);
      end
      // After 260 lines: port 0 outside its window, port 1 uncropped
      rd(8'h50, 8'h02);
      rd(8'h51, 8'h04);
      rd(8'h52, 8'h01);
   endtask

   // Each port keeps its own window when the selected port is addressed
   task automatic t_per_port();
      multi <= 1'b1;
      en1 <= 1'b1;
      psel <= 1'b1;
      set_win(13'h0001, 13'h0001);
      psel <= 1'b0;
      set_win(13'h0003, 13'h0003);
      rd(8'h3A, 8'h03);
      psel <= 1'b1;
      rd(8'h3A, 8'h01);
      send_frame(5, 2);
      check_port(0, 16'h0003, 16'h0003, 16'h0002);
      check_port(1, 16'h0001, 16'h0001, 16'h0002);
   endtask

   // Main sequence
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_reg_access();
      t_windows();
      t_per_port();
      complete_run();
   end

   // Watchdog well beyond the expected run length
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      complete_run();
   end
endmodule

// >>> logic/vcw_defs.svh
`ifndef VCW_DEFS_SVH
`define VCW_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define VCW_OFF_FIRST_LO   8'h3A
`define VCW_OFF_FIRST_HI   8'h3B
`define VCW_OFF_LAST_LO    8'h3C
`define VCW_OFF_LAST_HI    8'h3D
`define VCW_OFF_STATUS     8'h50
`define VCW_OFF_LINE_LO    8'h51
`define VCW_OFF_LINE_HI    8'h52

// ----------------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------------
`define VCW_LOW_W          8
`define VCW_HIGH_W         5
`define VCW_LINE_W         13
`define VCW_HIGH_MASK      8'h1F
`define VCW_RESET_BYTE     8'h00
`define VCW_LINE_MAX       13'h1FFF
`define VCW_LINE_ONE       13'h0001
`define VCW_NUM_PORTS      2

`endif

// >>> logic/vcw_line_gate.sv
`timescale 1ns/100ps
`include "vcw_defs.svh"

module vcw_line_gate #(
   parameter int DATA_W = 24
) (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                rst,
   // Window control
   input  wire logic                enable,
   input  wire logic [12:0]         first_line,
   input  wire logic [12:0]         last_line,
   // Video in
   input  wire logic                frame_start,
   input  wire logic                in_valid,
   input  wire logic [DATA_W-1:0]   in_data,
   input  wire logic                in_hsync,
   input  wire logic                in_vsync,
   // Video out
   output logic                     out_valid,
   output logic      [DATA_W-1:0]   out_data,
   output logic                     out_hsync,
   output logic                     out_vsync,
   // Status
   output logic      [12:0]         line_index,
   output logic                     line_kept
);

   vcw_pkg::vcw_gate_state_t state_q, state_d;
   vcw_pkg::vcw_line_t       idx_q, idx_d, cur_idx;
   logic                     keep;
   logic                     valid_q, valid_d;
   logic [DATA_W-1:0]        data_q, data_d;
   logic                     hs_q, hs_d;
   logic                     vs_q, vs_d;

   // ----------------------------------------------------------------------
   // Line counter: zero at frame start, steps at the end of each line
   // ----------------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      idx_d   = idx_q;
      if (frame_start) begin
         idx_d   = 13'h0000;                                  // see RQ5, see RQ10
         state_d = in_valid ? vcw_pkg::VCW_ST_LINE : vcw_pkg::VCW_ST_GAP;
      end else begin
         case (state_q)
            vcw_pkg::VCW_ST_GAP: begin
               if (in_valid) begin
                  state_d = vcw_pkg::VCW_ST_LINE;
               end
            end
            vcw_pkg::VCW_ST_LINE: begin
               if (!in_valid) begin
                  state_d = vcw_pkg::VCW_ST_GAP;
                  // Saturate so an endless frame never wraps back into the window
                  if (idx_q != `VCW_LINE_MAX) begin
                     idx_d = 13'(idx_q + `VCW_LINE_ONE);       // see RQ10
                  end
               end
            end
            default: begin
               state_d = vcw_pkg::VCW_ST_GAP;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= vcw_pkg::VCW_ST_GAP;
         idx_q   <= 13'h0000;
      end else begin
         state_q <= state_d;
         idx_q   <= idx_d;
      end
   end

   // ----------------------------------------------------------------------
   // Window compare, inclusive on both ends; first above last passes none
   // ----------------------------------------------------------------------
   assign cur_idx = frame_start ? 13'h0000 : idx_q;
   assign keep    = !enable                                    // see RQ9
                    || ((cur_idx >= first_line)                // see RQ1, see RQ2
                    && (cur_idx <= last_line));                // see RQ3, see RQ4

   // Output stage; sync and timing pass, only the valid flag and data blank
   always_comb begin
      valid_d = in_valid && keep;                              // see RQ2, see RQ4
      data_d  = (in_valid && keep) ? in_data : '0;
      hs_d    = in_hsync;
      vs_d    = in_vsync;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         valid_q <= 1'b0;
         data_q  <= '0;
         hs_q    <= 1'b0;
         vs_q    <= 1'b0;
      end else begin
         valid_q <= valid_d;
         data_q  <= data_d;
         hs_q    <= hs_d;
         vs_q    <= vs_d;
      end
   end

   assign out_valid  = valid_q;
   assign out_data   = data_q;
   assign out_hsync  = hs_q;
   assign out_vsync  = vs_q;
   assign line_index = idx_q;
   assign line_kept  = keep;

endmodule

// >>> logic/vcw_pkg.sv
package vcw_pkg;

   // Line index type
   typedef logic [12:0] vcw_line_t;

   // Register selector produced by the address decoder
   typedef enum logic [2:0] {
      VCW_IDX_FIRST_LO = 3'b000,
      VCW_IDX_FIRST_HI = 3'b001,
      VCW_IDX_LAST_LO  = 3'b010,
      VCW_IDX_LAST_HI  = 3'b011,
      VCW_IDX_STATUS   = 3'b100,
      VCW_IDX_LINE_LO  = 3'b101,
      VCW_IDX_LINE_HI  = 3'b110,
      VCW_IDX_NONE     = 3'b111
   } vcw_reg_idx_t;

   // Line gate state: between lines or inside an active line
   typedef enum logic {
      VCW_ST_GAP  = 1'b0,
      VCW_ST_LINE = 1'b1
   } vcw_gate_state_t;

endpackage

// >>> logic/vcw_reg_mem.sv
`timescale 1ns/100ps
`include "vcw_defs.svh"

module vcw_reg_mem #(
   parameter int PORTS = `VCW_NUM_PORTS
) (
   // Clock and reset
   input  wire logic                      clk,
   input  wire logic                      rst,
   // Write side
   input  wire logic [PORTS-1:0]          wr_port,
   input  wire logic [1:0]                wr_idx,
   input  wire logic [7:0]                wr_data,
   // Read side
   input  wire logic                      rd_en,
   input  wire logic                      rd_port,
   input  wire logic [1:0]                rd_idx,
   output logic      [7:0]                rd_data,
   // Window values per port
   output logic      [PORTS*13-1:0]       first_line,
   output logic      [PORTS*13-1:0]       last_line
);

   logic [7:0] mem_q [PORTS][4];
   logic [7:0] mem_d [PORTS][4];
   logic [7:0] rd_q;
   logic [7:0] rd_d;

   // ----------------------------------------------------------------------
   // Storage; high bytes keep only five bits so reserved bits read zero
   // ----------------------------------------------------------------------
   always_comb begin
      mem_d = mem_q;
      for (int p = 0; p < PORTS; p++) begin
         if (wr_port[p]) begin
            if (wr_idx[0]) begin
               mem_d[p][wr_idx] = wr_data & `VCW_HIGH_MASK;   // see RQ6, see RQ7
            end else begin
               mem_d[p][wr_idx] = wr_data;
            end
         end
      end
      rd_d = rd_en ? mem_q[rd_port][rd_idx] : `VCW_RESET_BYTE;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         for (int p = 0; p < PORTS; p++) begin
            for (int i = 0; i < 4; i++) begin
               mem_q[p][i] <= `VCW_RESET_BYTE;
            end
         end
         rd_q <= `VCW_RESET_BYTE;
      end else begin
         mem_q <= mem_d;
         rd_q  <= rd_d;
      end
   end

   assign rd_data = rd_q;

   // ----------------------------------------------------------------------
   // Assemble 13-bit values: high byte bits 4:0 above the low byte
   // ----------------------------------------------------------------------
   for (genvar g = 0; g < PORTS; g++) begin : g_val
      assign first_line[g*13 +: 13] = {mem_q[g][1][4:0], mem_q[g][0]};   // see RQ6
      assign last_line[g*13 +: 13]  = {mem_q[g][3][4:0], mem_q[g][2]};   // see RQ7
   end

endmodule

// >>> logic/vcw_top.sv
`timescale 1ns/100ps
`include "vcw_defs.svh"

// Function
// RQ1 - First-line value marks earliest passed line
// RQ2 - Lines before first line go blank
// RQ3 - Last-line value marks final passed line
// RQ4 - Lines after last line go blank
// RQ5 - Line index starts at zero per frame
// RQ6 - First line: 13 bits, low and high bytes
// RQ7 - Last line: 13 bits, low and high bytes
// RQ8 - Multi-port modes: settings hit selected port only
// RQ9 - Crop only while port enable is set
// RQ10 - Line counter restarts per frame, inclusive compare
module vcw_top #(
   parameter int DATA_W = 24
) (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                rst,
   // Register port
   input  wire logic [7:0]          reg_addr,
   input  wire logic [7:0]          reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic      [7:0]          reg_rdata,
   // Mode and port selection
   input  wire logic                multi_port_mode,
   input  wire logic                port_select,
   input  wire logic                crop_enable_p0,
   input  wire logic                crop_enable_p1,
   // Video from the serial input side
   input  wire logic                vid_frame_start,
   input  wire logic                vid_pixel_valid_flag,
   input  wire logic [DATA_W-1:0]   vid_data,
   input  wire logic                vid_hsync,
   input  wire logic                vid_vsync,
   // Transmit path, first port
   output logic                     tx0_pixel_valid_flag,
   output logic      [DATA_W-1:0]   tx0_data,
   output logic                     tx0_hsync,
   output logic                     tx0_vsync,
   // Transmit path, second port
   output logic                     tx1_pixel_valid_flag,
   output logic      [DATA_W-1:0]   tx1_data,
   output logic                     tx1_hsync,
   output logic                     tx1_vsync
);

   localparam int PORTS = `VCW_NUM_PORTS;

   // ----------------------------------------------------------------------
   // Address decoder
   // ----------------------------------------------------------------------
   // Shared by the write and the read path so both agree on the map
   function automatic vcw_pkg::vcw_reg_idx_t vcw_decode(input logic [7:0] addr);
      vcw_pkg::vcw_reg_idx_t sel;
      if (addr == `VCW_OFF_FIRST_LO) begin
         sel = vcw_pkg::VCW_IDX_FIRST_LO;
      end else if (addr == `VCW_OFF_FIRST_HI) begin
         sel = vcw_pkg::VCW_IDX_FIRST_HI;
      end else if (addr == `VCW_OFF_LAST_LO) begin
         sel = vcw_pkg::VCW_IDX_LAST_LO;
      end else if (addr == `VCW_OFF_LAST_HI) begin
         sel = vcw_pkg::VCW_IDX_LAST_HI;
      end else if (addr == `VCW_OFF_STATUS) begin
         sel = vcw_pkg::VCW_IDX_STATUS;
      end else if (addr == `VCW_OFF_LINE_LO) begin
         sel = vcw_pkg::VCW_IDX_LINE_LO;
      end else if (addr == `VCW_OFF_LINE_HI) begin
         sel = vcw_pkg::VCW_IDX_LINE_HI;
      end else begin
         sel = vcw_pkg::VCW_IDX_NONE;
      end
      return sel;
   endfunction

   vcw_pkg::vcw_reg_idx_t wr_sel;
   vcw_pkg::vcw_reg_idx_t rd_sel;
   logic                  wr_window;
   logic                  rd_window;
   logic [PORTS-1:0]      wr_port;
   logic                  target_port;

   assign wr_sel    = vcw_decode(reg_addr);
   assign rd_sel    = vcw_decode(reg_addr);
   assign wr_window = reg_wr && (wr_sel[2] == 1'b0);
   assign rd_window = reg_rd && (rd_sel[2] == 1'b0);

   // ----------------------------------------------------------------------
   // Port steering
   // ----------------------------------------------------------------------
   // In the multi-port modes only the selected port sees a window or line-counter access;
   // otherwise both windows are written together so they never diverge
   // and those reads come from the first port. Status reads show the kept bits of both ports.
   always_comb begin
      target_port = multi_port_mode ? port_select : 1'b0;     // see RQ8
      wr_port     = '0;
      if (wr_window) begin
         if (multi_port_mode) begin
            wr_port[port_select] = 1'b1;                      // see RQ8
         end else begin
            wr_port = '1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Window storage
   // ----------------------------------------------------------------------
   logic [7:0]          mem_rdata;
   logic [PORTS*13-1:0] first_line;
   logic [PORTS*13-1:0] last_line;

   vcw_reg_mem #(
      .PORTS      (PORTS)
   ) u_mem (
      .clk        (clk),
      .rst        (rst),
      .wr_port    (wr_port),
      .wr_idx     (wr_sel[1:0]),
      .wr_data    (reg_wdata),
      .rd_en      (rd_window),
      .rd_port    (target_port),
      .rd_idx     (rd_sel[1:0]),
      .rd_data    (mem_rdata),
      .first_line (first_line),
      .last_line  (last_line)
   );

   // ----------------------------------------------------------------------
   // Per-port line gates
   // ----------------------------------------------------------------------
   logic [PORTS-1:0]        crop_en;
   logic [PORTS-1:0]        out_valid;
   logic [DATA_W-1:0]       out_data  [PORTS];
   logic [PORTS-1:0]        out_hsync;
   logic [PORTS-1:0]        out_vsync;
   logic [12:0]             line_idx  [PORTS];
   logic [PORTS-1:0]        line_kept;

   assign crop_en = {crop_enable_p1, crop_enable_p0};

   for (genvar g = 0; g < PORTS; g++) begin : g_port
      vcw_line_gate #(
         .DATA_W      (DATA_W)
      ) u_gate (
         .clk         (clk),
         .rst         (rst),
         .enable      (crop_en[g]),
         .first_line  (first_line[g*13 +: 13]),
         .last_line   (last_line[g*13 +: 13]),
         .frame_start (vid_frame_start),
         .in_valid    (vid_pixel_valid_flag),
         .in_data     (vid_data),
         .in_hsync    (vid_hsync),
         .in_vsync    (vid_vsync),
         .out_valid   (out_valid[g]),
         .out_data    (out_data[g]),
         .out_hsync   (out_hsync[g]),
         .out_vsync   (out_vsync[g]),
         .line_index  (line_idx[g]),
         .line_kept   (line_kept[g])
      );
   end

   assign tx0_pixel_valid_flag = out_valid[0];
   assign tx0_data             = out_data[0];
   assign tx0_hsync            = out_hsync[0];
   assign tx0_vsync            = out_vsync[0];
   assign tx1_pixel_valid_flag = out_valid[1];
   assign tx1_data             = out_data[1];
   assign tx1_hsync            = out_hsync[1];
   assign tx1_vsync            = out_vsync[1];

   // ----------------------------------------------------------------------
   // Status read path
   // ----------------------------------------------------------------------
   // Status and the line counter are sampled at the read strobe, so a
   // value that moves during a two-byte read may tear; read high then low
   // twice if a consistent pair matters.
   logic [7:0] stat_q, stat_d;
   logic       from_mem_q, from_mem_d;
   logic [12:0] sel_line;

   assign sel_line = line_idx[target_port];

   always_comb begin
      stat_d     = `VCW_RESET_BYTE;
      from_mem_d = rd_window;
      if (reg_rd) begin
         if (rd_sel == vcw_pkg::VCW_IDX_STATUS) begin
            stat_d = {6'h00, line_kept};
         end else if (rd_sel == vcw_pkg::VCW_IDX_LINE_LO) begin
            stat_d = sel_line[7:0];
         end else if (rd_sel == vcw_pkg::VCW_IDX_LINE_HI) begin
            stat_d = {3'h0, sel_line[12:8]};
         end else begin
            stat_d = `VCW_RESET_BYTE;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         stat_q     <= `VCW_RESET_BYTE;
         from_mem_q <= 1'b0;
      end else begin
         stat_q     <= stat_d;
         from_mem_q <= from_mem_d;
      end
   end

   // Both sources are flops and the idle one holds zero, so unmapped reads return zero
   assign reg_rdata = from_mem_q ? mem_rdata : stat_q;

endmodule
